/* core/spmg_pkg.sv */
// Package: register map, field positions, reset values and timing of the serial/pin port
package spmg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL = 8'h68;
  localparam logic [7:0] OFF_STATUS  = 8'h69;
  localparam logic [7:0] OFF_TX_BYTE = 8'h6A;
  localparam logic [7:0] OFF_RX_BYTE = 8'h6B;
  localparam logic [7:0] OFF_PULLUP  = 8'h6C;
  localparam logic [7:0] OFF_DIR     = 8'h6D;
  localparam logic [7:0] OFF_TSEL    = 8'h6E;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_SYNC_RESET = 7;
  localparam int CTL_BOOT_SEL   = 6;
  localparam int CTL_ROLE       = 5;
  localparam int CTL_FUNC       = 4;
  localparam int CTL_PHASE      = 3;
  localparam int CTL_IDLE       = 2;
  localparam int CTL_DIV_LO     = 0;
  localparam int ST_OVERRUN     = 2;
  localparam int ST_RX_READY    = 1;
  localparam int ST_TX_FREE     = 0;
  localparam int TSEL_MULTI     = 2;
  localparam int PAD_SCK        = 0;
  localparam int PAD_MISO       = 1;
  localparam int PAD_MOSI       = 2;
  localparam int PAD_NSS0       = 3;
  localparam int PAD_NSS_FIRST  = 4;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h70;
  localparam logic [7:0] TX_RESET      = 8'h00;
  localparam logic [7:0] PULLUP_RESET  = 8'hFF;
  localparam logic [7:0] DIR_RESET     = 8'h00;
  localparam logic [2:0] TSEL_RESET    = 3'h0;
  localparam logic       TX_FREE_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Timing: the system clock stands in for the RC clock
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ  = 25_000_000;
  localparam int SLOW_CLK_HZ = 4_000;
  localparam int DIV_RC2     = 2;
  localparam int DIV_RC8     = 8;
  localparam int DIV_RC16    = 16;
  localparam logic [11:0] HALF_RC2  = 12'(DIV_RC2 / 2);
  localparam logic [11:0] HALF_RC8  = 12'(DIV_RC8 / 2);
  localparam logic [11:0] HALF_RC16 = 12'(DIV_RC16 / 2);
  localparam logic [11:0] HALF_SLOW = 12'(SYS_CLK_HZ / (2 * SLOW_CLK_HZ));
  localparam logic [4:0]  LAST_EDGE = 5'h0F;

  typedef enum {SPMG_IDLE, SPMG_RUN} spmg_state_e;

endpackage

/* core/spmg_port.sv */
// Module: byte-wide serial port, controller or target, with general-purpose pin mode
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Implementation choice: the address-and-strobe port.
module spmg_port (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  output logic      [7:0] rd_data_o,
  input  wire logic [7:0] pad_in_i,
  output logic      [7:0] pad_out_o,
  output logic      [7:0] pad_oe_o,
  output logic      [7:0] pad_pullup_o,
  output logic            irq_rx_ready_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [11:0] half_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    return spmg_pkg::HALF_RC2;
      2'h1:    return spmg_pkg::HALF_RC8;
      2'h2:    return spmg_pkg::HALF_RC16;
      default: return spmg_pkg::HALF_SLOW;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  ctl_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  pull_reg;
  logic [7:0]  dir_reg;
  logic [2:0]  tsel_reg;
  logic [7:0]  rx_hold_reg;
  logic        tx_free_reg;
  logic        rx_ready_reg;
  logic        overrun_reg;
  logic [7:0]  s1_reg;
  logic [7:0]  s2_reg;
  logic [7:0]  s3_reg;
  logic [7:0]  pin_reg;
  logic        sck_prev_reg;
  logic        tgt_prev_reg;
  logic [11:0] half_cnt_reg;
  logic [4:0]  edge_cnt_reg;
  logic [7:0]  shift_reg;
  logic        out_bit_reg;
  logic        rx_bit_reg;
  logic        sck_reg;
  logic        start_pend_reg;
  spmg_pkg::spmg_state_e state_reg;

  logic        wr_ctl;
  logic        wr_status;
  logic        wr_tx;
  logic        rd_rx;
  logic        sync_clr;
  logic        serial_mode;
  logic        ctrl_role;
  logic        phase1;
  logic        idle_lvl;
  logic        multi;
  logic        ctrl_on;
  logic        tgt_active;
  logic        half_tick;
  logic        start_req;
  logic        tgt_load;
  logic        eng_edge;
  logic        eng_lead;
  logic        eng_in;
  logic        done;
  logic        load;
  logic [7:0]  new_byte;

  // ----------------------------------------------------------------
  // Decode and mode
  // ----------------------------------------------------------------
  // Write and read strobes per register
  assign wr_ctl    = wr_en_i && hit(addr_i, spmg_pkg::OFF_CONTROL);
  assign wr_status = wr_en_i && hit(addr_i, spmg_pkg::OFF_STATUS);
  assign wr_tx     = wr_en_i && hit(addr_i, spmg_pkg::OFF_TX_BYTE);
  assign rd_rx     = rd_en_i && hit(addr_i, spmg_pkg::OFF_RX_BYTE);
  assign sync_clr  = wr_ctl && wr_data_i[spmg_pkg::CTL_SYNC_RESET];

  // Mode fields
  assign serial_mode = ctl_reg[spmg_pkg::CTL_FUNC];
  assign ctrl_role   = ctl_reg[spmg_pkg::CTL_ROLE];
  assign phase1      = ctl_reg[spmg_pkg::CTL_PHASE];
  assign idle_lvl    = ctl_reg[spmg_pkg::CTL_IDLE];
  assign multi       = tsel_reg[spmg_pkg::TSEL_MULTI];
  assign ctrl_on     = serial_mode && ctrl_role;
  // Target is selected while select 0 is seen low
  assign tgt_active  = serial_mode && !ctrl_role && !pin_reg[spmg_pkg::PAD_NSS0];

  // Transfer triggers; a status write during a byte is held as pending
  assign start_req = ctrl_on && state_reg == spmg_pkg::SPMG_IDLE
                     && (wr_status || start_pend_reg);
  assign tgt_load  = tgt_active && !tgt_prev_reg;
  assign half_tick = state_reg == spmg_pkg::SPMG_RUN
                     && half_cnt_reg == half_limit(ctl_reg[1:0]) - 12'h001;

  // Edge sources: own divider as controller, pin edges as target.
  // The target path relies on the far controller keeping SCK slow enough.
  assign eng_edge = ctrl_on ? half_tick
                            : (tgt_active && pin_reg[spmg_pkg::PAD_SCK] != sck_prev_reg);
  assign eng_lead = ctrl_on ? !edge_cnt_reg[0] : (pin_reg[spmg_pkg::PAD_SCK] != idle_lvl);
  assign eng_in   = ctrl_on ? pin_reg[spmg_pkg::PAD_MISO] : pin_reg[spmg_pkg::PAD_MOSI];
  assign done     = eng_edge && !eng_lead && edge_cnt_reg == spmg_pkg::LAST_EDGE;
  assign load     = start_req || tgt_load || (done && !ctrl_on);
  assign new_byte = {shift_reg[6:0], phase1 ? eng_in : rx_bit_reg};

  // ----------------------------------------------------------------
  // Pad input synchroniser
  // ----------------------------------------------------------------
  // A pad change counts once the second and third stages agree
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_reg  <= 8'hFF;
      s2_reg  <= 8'hFF;
      s3_reg  <= 8'hFF;
      pin_reg <= 8'hFF;
    end
    else
    begin
      s1_reg  <= pad_in_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= (pin_reg & (s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Reset leaves the port as controller with select 0 high, ready to boot
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctl_reg  <= spmg_pkg::CONTROL_RESET;
      tx_reg   <= spmg_pkg::TX_RESET;
      pull_reg <= spmg_pkg::PULLUP_RESET;
      dir_reg  <= spmg_pkg::DIR_RESET;
      tsel_reg <= spmg_pkg::TSEL_RESET;
    end
    else
    begin
      if (wr_ctl)
        ctl_reg <= wr_data_i;
      if (wr_tx)
        tx_reg <= wr_data_i;
      if (wr_en_i && hit(addr_i, spmg_pkg::OFF_PULLUP))
        pull_reg <= wr_data_i;
      if (wr_en_i && hit(addr_i, spmg_pkg::OFF_DIR))
        dir_reg <= wr_data_i;
      if (wr_en_i && hit(addr_i, spmg_pkg::OFF_TSEL))
        tsel_reg <= wr_data_i[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Hardware set wins over software clear on every flag
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_free_reg  <= spmg_pkg::TX_FREE_RESET;
      rx_ready_reg <= 1'b0;
      overrun_reg  <= 1'b0;
      rx_hold_reg  <= 8'h00;
    end
    else
    begin
      if (load)
        tx_free_reg <= 1'b1;
      else if (wr_tx)
        tx_free_reg <= 1'b0;
      if (done)
      begin
        rx_ready_reg <= 1'b1;
        rx_hold_reg  <= new_byte;
      end
      else if (rd_rx)
        rx_ready_reg <= 1'b0;
      if (done && rx_ready_reg && !rd_rx)
        overrun_reg <= 1'b1;
      else if (wr_status && wr_data_i[spmg_pkg::ST_OVERRUN])
        overrun_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  // One shifter serves both roles; the holding registers around it let
  // the next byte be queued while this one shifts.
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg      <= spmg_pkg::SPMG_IDLE;
      half_cnt_reg   <= 12'h000;
      edge_cnt_reg   <= 5'h00;
      shift_reg      <= 8'h00;
      out_bit_reg    <= 1'b0;
      rx_bit_reg     <= 1'b0;
      sck_reg        <= 1'b0;
      start_pend_reg <= 1'b0;
      sck_prev_reg   <= 1'b1;
      tgt_prev_reg   <= 1'b0;
    end
    else
    begin
      sck_prev_reg <= pin_reg[spmg_pkg::PAD_SCK];
      tgt_prev_reg <= tgt_active;
      if (sync_clr || !ctrl_on)
      begin
        // Counters cleared; the shifter keeps its data
        state_reg      <= spmg_pkg::SPMG_IDLE;
        half_cnt_reg   <= 12'h000;
        start_pend_reg <= 1'b0;
        sck_reg        <= idle_lvl;
        // A selected target keeps its bit count between pad edges
        if (sync_clr || !tgt_active)
          edge_cnt_reg <= 5'h00;
      end
      else if (wr_status && state_reg == spmg_pkg::SPMG_RUN)
        start_pend_reg <= 1'b1;
      case (state_reg)
        spmg_pkg::SPMG_IDLE:
        begin
          if (!sync_clr && ctrl_on)
            sck_reg <= idle_lvl;
          if (!sync_clr && start_req)
          begin
            state_reg      <= spmg_pkg::SPMG_RUN;
            start_pend_reg <= 1'b0;
            half_cnt_reg   <= 12'h000;
            edge_cnt_reg   <= 5'h00;
          end
        end
        spmg_pkg::SPMG_RUN:
        begin
          if (!sync_clr && ctrl_on)
          begin
            if (half_tick)
            begin
              half_cnt_reg <= 12'h000;
              sck_reg      <= ~sck_reg;
              if (done)
                state_reg <= spmg_pkg::SPMG_IDLE;
            end
            else
              half_cnt_reg <= half_cnt_reg + 12'h001;
          end
        end
        default:
          state_reg <= spmg_pkg::SPMG_IDLE;
      endcase
      // Shifting, msb first; phase picks which edge samples
      if (!sync_clr && load)
      begin
        shift_reg    <= tx_reg;
        out_bit_reg  <= tx_reg[7];
        // Restart the count so a back-to-back target byte ends on edge 16
        edge_cnt_reg <= 5'h00;
      end
      else if (!sync_clr && eng_edge)
      begin
        edge_cnt_reg <= edge_cnt_reg + 5'h01;
        if (eng_lead)
        begin
          if (phase1)
            out_bit_reg <= shift_reg[7];
          else
            rx_bit_reg <= eng_in;
        end
        else
        begin
          shift_reg <= new_byte;
          if (!phase1)
            out_bit_reg <= shift_reg[6];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pads and read port
  // ----------------------------------------------------------------
  // Pad drive; the upper selects are plain pins except the one picked by tsel_reg in multi-target controller mode
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pad_out_o    <= spmg_pkg::TX_RESET;
      pad_oe_o     <= spmg_pkg::DIR_RESET;
      pad_pullup_o <= spmg_pkg::PULLUP_RESET;
    end
    else
    begin
      pad_out_o    <= tx_reg;
      pad_oe_o     <= dir_reg;
      pad_pullup_o <= pull_reg;
      if (serial_mode)
      begin
        // Pads 3:0 change hands in serial mode, plus the selected upper pad's output in multi-target controller mode
        if (ctrl_role)
        begin
          pad_out_o[spmg_pkg::PAD_SCK]  <= sck_reg;
          pad_out_o[spmg_pkg::PAD_MOSI] <= out_bit_reg;
          pad_out_o[spmg_pkg::PAD_NSS0] <= multi | ctl_reg[spmg_pkg::CTL_BOOT_SEL];
          pad_oe_o[3:0]                 <= 4'hD;
          if (multi)
            pad_out_o[spmg_pkg::PAD_NSS_FIRST + 32'(tsel_reg[1:0])]
              <= ctl_reg[spmg_pkg::CTL_BOOT_SEL];
        end
        else
        begin
          pad_out_o[spmg_pkg::PAD_MISO] <= out_bit_reg;
          pad_oe_o[3:0]                 <= {2'h0, tgt_active, 1'b0};
        end
      end
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rd_data_o <= 8'h00;
    else if (rd_en_i)
    begin
      case (addr_i)
        spmg_pkg::OFF_CONTROL: rd_data_o <= ctl_reg;
        spmg_pkg::OFF_STATUS:  rd_data_o <= {5'h00, overrun_reg, rx_ready_reg, tx_free_reg};
        spmg_pkg::OFF_TX_BYTE: rd_data_o <= tx_reg;
        spmg_pkg::OFF_RX_BYTE: rd_data_o <= serial_mode ? rx_hold_reg : pin_reg;
        spmg_pkg::OFF_PULLUP:  rd_data_o <= pull_reg;
        spmg_pkg::OFF_DIR:     rd_data_o <= dir_reg;
        spmg_pkg::OFF_TSEL:    rd_data_o <= {5'h00, tsel_reg};
        default:               rd_data_o <= 8'h00;
      endcase
    end
    else
      rd_data_o <= 8'h00;
  end

  // Receive ready goes straight to the interrupt controller
  assign irq_rx_ready_o = rx_ready_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  chk_start_runs: assert property (start_req && !sync_clr |=> state_reg == spmg_pkg::SPMG_RUN && tx_free_reg)
    else $error("status write did not start a transfer");
  chk_txfree_clear: assert property (wr_tx && !load |=> !tx_free_reg)
    else $error("transmit free flag not cleared by data write");
  chk_rx_landed: assert property (done |=> rx_ready_reg && rx_hold_reg == $past(new_byte))
    else $error("received byte not latched with ready flag");
  chk_rx_read_clear: assert property (rd_rx && !done |=> !rx_ready_reg)
    else $error("receive ready not cleared by read");
  chk_overrun_set: assert property (done && rx_ready_reg && !rd_rx |=> overrun_reg)
    else $error("overrun not flagged");
  chk_boot_select: assert property (ctrl_on && !multi |=> pad_oe_o[3] && pad_out_o[3] == $past(ctl_reg[6]))
    else $error("select 0 not following control bit");
  chk_upper_pins: assert property (1'b1 |=> pad_oe_o[7:4] == $past(dir_reg[7:4]))
    else $error("upper select pads not under direction register");
  chk_sck_idle: assert property ((ctrl_on && state_reg == spmg_pkg::SPMG_IDLE && $stable(ctl_reg))[*3]
                                 |-> pad_out_o[0] == idle_lvl)
    else $error("clock pad not at idle level");
  chk_sync_clear: assert property (sync_clr |=> state_reg == spmg_pkg::SPMG_IDLE && edge_cnt_reg == 5'h00)
    else $error("counters not cleared by sync reset");

  cov_ctrl_byte: cover property (ctrl_on && done);
  cov_tgt_byte:  cover property (!ctrl_role && done);
  cov_overrun:   cover property (done && rx_ready_reg);
  cov_pin_mode:  cover property (!serial_mode && rd_rx);

endmodule // spmg_port

/* verif/spmg_target_model.sv */
// Far-side serial target model: answers on MISO and captures MOSI
module spmg_target_model (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_b_i,
  input  wire logic [7:0] resp_i,
  output logic            miso_o,
  output logic      [7:0] got_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_sr;
  int         n_fall;
  // Select low loads the answer byte, as the boot memory does
  always @(negedge sel_b_i)
  begin
    tx_sr  = resp_i;
    n_fall = 0;
  end
  // Idle-low, phase 0 only: sample on rising, shift on falling
  always @(posedge sck_i)
    if (!sel_b_i) got_o = {got_o[6:0], mosi_i};
  // Reload after eight bits so back-to-back bytes repeat the answer
  always @(negedge sck_i)
    if (!sel_b_i)
    begin
      n_fall++;
      tx_sr = (n_fall % 8 == 0) ? resp_i : {tx_sr[6:0], 1'b1};
    end
  // A released line floats to the pull-up level
  assign miso_o = sel_b_i ? 1'b1 : tx_sr[7];
endmodule // spmg_target_model

/* verif/testbench.sv */
// Self-checking bench for the serial/pin port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys_i = 1'b0;
  logic       rst_b_i   = 1'b0;
  logic [7:0] addr_i    = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic       wr_en_i   = 1'b0;
  logic       rd_en_i   = 1'b0;
  logic       ext_en    = 1'b0;
  logic [7:0] ext_val   = 8'h00;
  logic [7:0] rd_data_o, pad_out_o, pad_oe_o, pad_pullup_o, pad_in_i, got;
  logic       irq_rx_ready_o, miso;
  logic [15:0] k;
  logic [7:0] miso_byte;
  int         num_errors = 0;
  int         n_compared = 0;
  int         cycles     = 0;
  int         half[3]    = '{1, 4, 8};
  // Wire level: our drive wins, else bench pads, else model MISO and pull-ups
  assign pad_in_i = (pad_oe_o & pad_out_o)
                  | (~pad_oe_o & (ext_en ? ext_val : {6'h3F, miso, 1'b1}));
  spmg_port u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
    .pad_pullup_o(pad_pullup_o), .irq_rx_ready_o(irq_rx_ready_o));
  spmg_target_model u_far (.sck_i(pad_out_o[0]), .mosi_i(pad_out_o[2]),
    .sel_b_i(pad_out_o[3]), .resp_i(8'h3C), .miso_o(miso), .got_o(got));
  // Clock at 25 MHz
  initial forever #20 clk_sys_i = ~clk_sys_i;
  // Hang guard: the run needs about 10000 cycles
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] v, input logic [15:0] e);
    n_compared++;
    if (v !== e)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, v, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_en_i   <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge clk_sys_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    rd_en_i <= 1'b1;
    addr_i  <= a;
    @(posedge clk_sys_i);
    rd_en_i <= 1'b0;
    #1 check(rd_data_o, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Count system cycles for which SCK stays high after its first rise
  task automatic measure();
    k = 16'h0000;
    wait (pad_out_o[0] === 1'b1);
    while (pad_out_o[0] === 1'b1 && k < 16'h0FFF)
    begin
      @(posedge clk_sys_i);
      #1 k++;
    end
  endtask
  // Outside controller, phase 0, idle low: each SCK level held 8 cycles
  task automatic tgt_byte(input logic [7:0] d, output logic [7:0] q);
    for (int b = 7; b >= 0; b--)
    begin
      ext_val <= {4'hF, 1'b0, d[b], 2'b10};
      repeat (8) @(posedge clk_sys_i);
      q[b] = pad_out_o[1];
      ext_val <= {4'hF, 1'b0, d[b], 2'b11};
      repeat (8) @(posedge clk_sys_i);
    end
    ext_val <= {4'hF, 1'b0, d[0], 2'b10};
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic conclude();
    $display("Errors %0d, comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(spmg_pkg::OFF_CONTROL, 8'h70);
    rd(spmg_pkg::OFF_STATUS, 8'h01);
    rd(spmg_pkg::OFF_TX_BYTE, 8'h00);
    rd(spmg_pkg::OFF_PULLUP, 8'hFF);
    rd(spmg_pkg::OFF_DIR, 8'h00);
    rd(8'h6F, 8'h00);
    wr(spmg_pkg::OFF_TSEL, 8'hFF);
    rd(spmg_pkg::OFF_TSEL, 8'h07);
    wr(spmg_pkg::OFF_PULLUP, 8'h5A);
    settle(2);
    check(pad_pullup_o, 8'h5A);
    // Lower direction bits must not steal serial pads
    wr(spmg_pkg::OFF_DIR, 8'hF2);
    wr(spmg_pkg::OFF_CONTROL, 8'h76);
    settle(3);
    check(pad_oe_o, 8'hFD);
    check({pad_out_o[7], pad_out_o[3], pad_out_o[0]}, 3'b111);
    // Leave multi-target mode, then drop SCK before select so no false edge
    wr(spmg_pkg::OFF_TSEL, 8'h00);
    wr(spmg_pkg::OFF_CONTROL, 8'h72);
    wr(spmg_pkg::OFF_CONTROL, 8'h32);
    wr(spmg_pkg::OFF_TX_BYTE, 8'hA5);
    rd(spmg_pkg::OFF_STATUS, 8'h00);
    wr(spmg_pkg::OFF_STATUS, 8'h00);
    for (int i = 0; i < 400 && irq_rx_ready_o !== 1'b1; i++) @(posedge clk_sys_i);
    check(irq_rx_ready_o, 1'b1);
    check(got, 8'hA5);
    rd(spmg_pkg::OFF_RX_BYTE, 8'h3C);
    rd(spmg_pkg::OFF_STATUS, 8'h01);
    // Slow clock, then abort it: SCK must not rise again
    wr(spmg_pkg::OFF_CONTROL, 8'h73);
    wr(spmg_pkg::OFF_STATUS, 8'h00);
    measure();
    check(k, 16'd3125);
    wr(spmg_pkg::OFF_CONTROL, 8'hF3);
    settle(3200);
    check(pad_out_o[0], 1'b0);
    // Remaining dividers, bytes left unread to force an overrun
    for (int d = 0; d < 3; d++)
    begin
      wr(spmg_pkg::OFF_CONTROL, 8'h30 | 8'(d));
      wr(spmg_pkg::OFF_STATUS, 8'h00);
      measure();
      check(k, 16'(half[d]));
      settle(16 * half[d] + 4);
    end
    rd(spmg_pkg::OFF_STATUS, 8'h07);
    rd(spmg_pkg::OFF_RX_BYTE, 8'h3C);
    rd(spmg_pkg::OFF_STATUS, 8'h05);
    // Target role: the bench plays the outside controller on the pads
    ext_val <= 8'hFA;
    ext_en  <= 1'b1;
    wr(spmg_pkg::OFF_CONTROL, 8'h10);
    wr(spmg_pkg::OFF_TX_BYTE, 8'h5A);
    repeat (8) @(posedge clk_sys_i);
    tgt_byte(8'hC3, miso_byte);
    ext_val <= 8'hFA;
    check(miso_byte, 8'h5A);
    check(irq_rx_ready_o, 1'b1);
    rd(spmg_pkg::OFF_RX_BYTE, 8'hC3);
    // Pin mode: overrun clear, pad outputs and pad inputs
    wr(spmg_pkg::OFF_CONTROL, 8'h00);
    wr(spmg_pkg::OFF_STATUS, 8'h04);
    rd(spmg_pkg::OFF_STATUS, 8'h01);
    wr(spmg_pkg::OFF_DIR, 8'hFF);
    wr(spmg_pkg::OFF_TX_BYTE, 8'h96);
    settle(2);
    check({pad_oe_o, pad_out_o}, 16'hFF96);
    wr(spmg_pkg::OFF_DIR, 8'h00);
    ext_en  <= 1'b1;
    ext_val <= 8'hC3;
    settle(6);
    rd(spmg_pkg::OFF_RX_BYTE, 8'hC3);
    conclude();
  end
endmodule // testbench
